// File: verilog/sbic_space_bus_ctrl.sv
/*
  Space bus idle-cycle controller: per-space control words on APB and a
  bus sequencer that inserts the programmed idle cycles between
  external accesses.
  Assumes requests come from logic on CLK, MANUAL_RESET and STANDBY
  too; external memories sit behind CS_N, RD_N and WE_N.
*/
//
// Functional notes
// - one 32-bit read/write word per space
// - power-on reset loads 0x36DB0600
// - manual reset and standby keep words
// - top bit reads zero, write zero
// - bits 30:28 idle after write
// - bits 27:25 read then write, other space
// - bits 24:22 read then write, same space
// - idle follows access to owning space
// - codes 0,1,2 give 0,1,2 cycles
// - codes 3..7 give 4,6,8,10,12
`timescale 1ns/1ps
module sbic_space_bus_ctrl #(
  parameter int BUS_DIV = sbic_pkg::BUS_DIV,
  parameter int ACCESS_TICKS = sbic_pkg::ACCESS_TICKS
) (
  // clock and resets
  input wire logic CLK,
  input wire logic RESET,
  input wire logic MANUAL_RESET,
  input wire logic STANDBY,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // internal access request
  input wire logic ACC_REQ,
  input wire sbic_pkg::sbic_acc_t ACC,
  output logic ACC_ACK,
  // external bus strobes
  output logic [7:0] CS_N,
  output logic RD_N,
  output logic WE_N
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sbic_pkg::sbic_state_t state;
  sbic_pkg::sbic_acc_t cur;
  sbic_pkg::sbic_ctrl_t cfg_prev;
  sbic_pkg::sbic_ctrl_t rd_word;
  sbic_pkg::sbic_ctrl_t wr_word;
  logic [2:0] prev_space;
  logic prev_write;
  logic prev_valid;
  logic [3:0] idle_target;
  logic [3:0] idle_left;
  logic [3:0] gap_ticks;
  logic [7:0] acc_left;
  logic [7:0] div_cnt;
  logic tick;
  logic [2:0] sel_code;
  logic seq_reset;
  logic apb_first;
  logic apb_done;
  logic addr_space;
  logic addr_status;
  logic mem_we;
  logic [31:0] status_word;

  assign seq_reset = RESET | MANUAL_RESET;

  // ----------------------------------------------------------------
  // bus clock enable
  // ----------------------------------------------------------------
  // one-cycle tick per bus clock; idle cycles count these ticks
  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (div_cnt == 8'(BUS_DIV - 1)) begin
      div_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // words 0..7 map to spaces 0,2,3,4,5A,5B,6A,6B in that order
  assign addr_space = (PADDR[7:5] == sbic_pkg::SBC_BASE[7:5]) && (PADDR[1:0] == 2'b00);
  assign addr_status = (PADDR == sbic_pkg::STATUS_ADDR);
  assign apb_first = PSEL && PENABLE && !PREADY;
  assign apb_done = PSEL && PENABLE && PREADY;

  // write lands at the completing edge
  assign mem_we = apb_done && PWRITE && addr_space;

  // top bit stored as zero whatever is written
  always_comb begin
    wr_word = sbic_pkg::sbic_ctrl_t'(PWDATA);
    wr_word.rsvd = 1'b0;
  end

  // live sequencer state for software
  assign status_word = {19'h0_0000, prev_valid, prev_write, prev_space,
                        idle_left, state};

  // ----------------------------------------------------------------
  // control word bank
  // ----------------------------------------------------------------
  sbic_ctrl_mem #(
    .DEPTH(sbic_pkg::SPACE_COUNT),
    .AW(sbic_pkg::SPACE_AW)
  ) u_mem (
    .CLK(CLK),
    .RESET(RESET),
    .WR_EN(mem_we),
    .WR_ADDR(PADDR[4:2]),
    .WR_DATA(wr_word),
    .RD_ADDR_A(PADDR[4:2]),
    .RD_DATA_A(rd_word),
    .RD_ADDR_B(prev_space),
    .RD_DATA_B(cfg_prev)
  );

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // two access cycles: the word read at setup is registered first
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (apb_first) begin
      PREADY <= 1'b1;
      PSLVERR <= !(addr_space || addr_status);
      if (PWRITE) begin
        PRDATA <= 32'h0000_0000;
      end else if (addr_space) begin
        PRDATA <= {1'b0, rd_word[30:0]};
      end else if (addr_status) begin
        PRDATA <= status_word;
      end else begin
        PRDATA <= sbic_pkg::UNMAPPED_READ;
      end
    end else if (apb_done) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // idle code selection
  // ----------------------------------------------------------------
  // read-read gaps belong to other fields and are not handled here
  always_comb begin
    sel_code = 3'b000;
    if (!prev_valid) begin
      sel_code = 3'b000;
    end else if (prev_write) begin
      sel_code = cfg_prev.write_follow_idle;
    end else if (cur.write && (cur.space == prev_space)) begin
      sel_code = cfg_prev.read_write_same_space_idle;
    end else if (cur.write) begin
      sel_code = cfg_prev.read_write_other_space_idle;
    end else begin
      sel_code = 3'b000;
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  // manual reset aborts a transfer but leaves the word bank alone;
  // standby only blocks new requests
  always_ff @(posedge CLK) begin
    if (seq_reset) begin
      state <= sbic_pkg::ST_IDLE;
      cur <= '0;
      idle_target <= 4'h0;
      idle_left <= 4'h0;
      gap_ticks <= 4'h0;
      acc_left <= 8'h00;
      prev_space <= 3'b000;
      prev_write <= 1'b0;
      prev_valid <= 1'b0;
      ACC_ACK <= 1'b0;
      CS_N <= 8'hFF;
      RD_N <= 1'b1;
      WE_N <= 1'b1;
    end else begin
      ACC_ACK <= 1'b0;
      case (state)
        sbic_pkg::ST_IDLE: begin
          if (ACC_REQ && !ACC_ACK && !STANDBY) begin
            cur <= ACC;
            state <= sbic_pkg::ST_LOOKUP;
          end
        end
        sbic_pkg::ST_LOOKUP: begin
          idle_target <= sbic_pkg::idle_decode(sel_code);
          idle_left <= sbic_pkg::idle_decode(sel_code);
          gap_ticks <= 4'h0;
          state <= sbic_pkg::ST_GAP;
        end
        sbic_pkg::ST_GAP: begin
          if (tick && (idle_left == 4'h0)) begin
            state <= sbic_pkg::ST_ACCESS;
            acc_left <= 8'(ACCESS_TICKS - 1);
            CS_N[cur.space] <= 1'b0;
            RD_N <= cur.write;
            WE_N <= !cur.write;
          end else if (tick) begin
            idle_left <= idle_left - 4'h1;
            gap_ticks <= gap_ticks + 4'h1;
          end
        end
        sbic_pkg::ST_ACCESS: begin
          if (tick && (acc_left == 8'h00)) begin
            // remember the space that owns the next gap
            prev_space <= cur.space;
            prev_write <= cur.write;
            prev_valid <= 1'b1;
            CS_N <= 8'hFF;
            RD_N <= 1'b1;
            WE_N <= 1'b1;
            ACC_ACK <= 1'b1;
            state <= sbic_pkg::ST_IDLE;
          end else if (tick) begin
            acc_left <= acc_left - 8'h01;
          end
        end
        default: begin
          state <= sbic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_TOP_BIT_ZERO: assert property (@(posedge CLK) disable iff (RESET)
    (PREADY && !PWRITE && PSEL) |-> (PRDATA[31] == 1'b0))
    else $error("reserved top bit read as one");

  AST_GAP_NO_STROBE: assert property (@(posedge CLK) disable iff (seq_reset)
    (state != sbic_pkg::ST_ACCESS) |-> (CS_N == 8'hFF && RD_N && WE_N))
    else $error("strobe active outside an access");

  AST_GAP_LENGTH: assert property (@(posedge CLK) disable iff (seq_reset)
    (state == sbic_pkg::ST_GAP && tick && idle_left == 4'h0)
      |-> (gap_ticks == idle_target) ##1 (state == sbic_pkg::ST_ACCESS))
    else $error("gap length differs from programmed count");

  AST_CODE_TWELVE: assert property (@(posedge CLK) disable iff (seq_reset)
    (state == sbic_pkg::ST_LOOKUP && sel_code == 3'b111) |=> (idle_target == 4'hC))
    else $error("code 111 did not give 12 idle cycles");

  AST_CODE_ONE: assert property (@(posedge CLK) disable iff (seq_reset)
    (state == sbic_pkg::ST_LOOKUP && sel_code == 3'b001) |=> (idle_target == 4'h1))
    else $error("code 001 did not give one idle cycle");

  AST_AFTER_WRITE: assert property (@(posedge CLK) disable iff (seq_reset)
    (state == sbic_pkg::ST_LOOKUP && prev_valid && prev_write)
      |=> (idle_target == sbic_pkg::idle_decode($past(cfg_prev.write_follow_idle))))
    else $error("write-follow gap not from bits 30:28");

  AST_RW_OTHER: assert property (@(posedge CLK) disable iff (seq_reset)
    (state == sbic_pkg::ST_LOOKUP && prev_valid && !prev_write && cur.write
      && cur.space != prev_space)
      |=> (idle_target == sbic_pkg::idle_decode($past(cfg_prev.read_write_other_space_idle))))
    else $error("read-write other space gap not from bits 27:25");

  AST_RW_SAME: assert property (@(posedge CLK) disable iff (seq_reset)
    (state == sbic_pkg::ST_LOOKUP && prev_valid && !prev_write && cur.write
      && cur.space == prev_space)
      |=> (idle_target == sbic_pkg::idle_decode($past(cfg_prev.read_write_same_space_idle))))
    else $error("read-write same space gap not from bits 24:22");

  AST_APB_TWO_CYCLES: assert property (@(posedge CLK) disable iff (RESET)
    (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
    else $error("apb answer not in second access cycle");

endmodule : sbic_space_bus_ctrl

// File: include/sbic_pkg.sv
/*
  Shared constants and types for the space bus idle-cycle controller:
  register layout, reset value, register map, state codes and the
  idle-cycle code table.
  Assumes a single 200 MHz clock and a 32-bit APB register bus.
*/
package sbic_pkg;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam int SPACE_COUNT = 8;
  localparam int SPACE_AW = 3;
  localparam logic [31:0] SBC_RESET = 32'h36DB_0600;
  localparam logic [7:0] SBC_BASE = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h20;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing defaults: CLK frequency in MHz, then counts in cycles of CLK and of the bus clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int BUS_DIV = 2;
  localparam int ACCESS_TICKS = 1;

  // ----------------------------------------------------------------
  // space bus control word layout, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsvd;
    logic [2:0] write_follow_idle;
    logic [2:0] read_write_other_space_idle;
    logic [2:0] read_write_same_space_idle;
    logic [21:0] other_bits;
  } sbic_ctrl_t;

  // access request from the internal side
  typedef struct packed {
    logic [2:0] space;
    logic write;
  } sbic_acc_t;

  // bus sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOOKUP = 4'b0010,
    ST_GAP = 4'b0100,
    ST_ACCESS = 4'b1000
  } sbic_state_t;

  // idle-cycle code to count of bus clock cycles
  function automatic logic [3:0] idle_decode(input logic [2:0] code);
    logic [3:0] n;
    n = 4'h0;
    case (code)
      3'b000: n = 4'h0;
      3'b001: n = 4'h1;
      3'b010: n = 4'h2;
      3'b011: n = 4'h4;
      3'b100: n = 4'h6;
      3'b101: n = 4'h8;
      3'b110: n = 4'hA;
      default: n = 4'hC;
    endcase
    return n;
  endfunction : idle_decode

endpackage : sbic_pkg

// File: verilog/sbic_ctrl_mem.sv
/*
  Bank of space bus control words, one per chip-select space, with one
  write port and two registered read ports.
  Assumes RESET is the power-on reset only; nothing else clears it.
*/
`timescale 1ns/1ps
module sbic_ctrl_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and power-on reset
  input wire logic CLK,
  input wire logic RESET,
  // write port
  input wire logic WR_EN,
  input wire logic [AW-1:0] WR_ADDR,
  input wire sbic_pkg::sbic_ctrl_t WR_DATA,
  // read ports
  input wire logic [AW-1:0] RD_ADDR_A,
  output sbic_pkg::sbic_ctrl_t RD_DATA_A,
  input wire logic [AW-1:0] RD_ADDR_B,
  output sbic_pkg::sbic_ctrl_t RD_DATA_B
);

  sbic_pkg::sbic_ctrl_t mem [DEPTH];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // power-on reset value
  // no manual reset or standby input exists here
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= sbic_pkg::SBC_RESET;
      end
    end else if (WR_EN) begin
      mem[WR_ADDR] <= WR_DATA;
    end
  end

  // registered reads; reset value shows right after release
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RD_DATA_A <= sbic_pkg::SBC_RESET;
      RD_DATA_B <= sbic_pkg::SBC_RESET;
    end else begin
      RD_DATA_A <= mem[RD_ADDR_A];
      RD_DATA_B <= mem[RD_ADDR_B];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESET_VALUE: assert property (@(posedge CLK)
    $past(RESET) |-> (RD_DATA_B == sbic_pkg::SBC_RESET))
    else $error("control word not at reset value after power-on reset");

  for (genvar g = 0; g < DEPTH; g++) begin : g_keep
    AST_WORD_KEPT: assert property (@(posedge CLK) disable iff (RESET)
      !(WR_EN && (WR_ADDR == AW'(g))) |=> $stable(mem[g]))
      else $error("control word changed without a write");
  end

endmodule : sbic_ctrl_mem

// File: test/sbic_mem_model.sv
/*
  External memory model: watches the chip selects and strobes, measures
  the idle gap before each access and the access length, counts misuse.
  Assumes registered active-low strobes from the controller on CLK.
*/
`timescale 1ns/1ps
module sbic_mem_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // strobes from the controller
  input wire logic [7:0] CS_N,
  input wire logic RD_N,
  input wire logic WE_N,
  // measurements
  output int gap,
  output int len,
  output int errs,
  output logic [7:0] cs
);
  int idle;
  logic act;

  // any select or strobe low means a bus cycle
  assign act = !RD_N || !WE_N || (CS_N != 8'hFF);

  always @(posedge CLK) begin
    if (RESET) begin
      idle <= 0;
      len <= 0;
      errs <= 0;
      gap <= 0;
      cs <= 8'hFF;
    end else if (act) begin
      // one select and exactly one strobe, else misuse
      if ($countones(~CS_N) != 1 || RD_N == WE_N) begin
        errs <= errs + 1;
      end
      cs <= CS_N;
      len <= (idle > 0) ? 1 : len + 1;
      if (idle > 0) begin
        gap <= idle;
      end
      idle <= 0;
    end else begin
      idle <= idle + 1;
    end
  end
endmodule : sbic_mem_model

// File: test/tb_sbic_space_bus_ctrl.sv
/*
  Testbench: APB register checks and measured idle gaps per code.
  Assumes the controller and the memory model compile before it.
*/
`timescale 1ns/1ps
module tb_sbic_space_bus_ctrl;
  localparam int DIV = 2;
  localparam int TICKS = 1;
  logic clk, reset, man_rst, stby, psel, penable, pwrite, acc_req;
  logic pready, pslverr, ack, rd_n, we_n, err;
  logic [7:0] paddr, cs_n, cs;
  logic [31:0] pwdata, prdata, rd;
  sbic_pkg::sbic_acc_t acc;
  int gap, len, merr, base, n, bad_count, comparisons;
  int tbl[8] = '{0, 1, 2, 4, 6, 8, 10, 12};

  sbic_space_bus_ctrl #(.BUS_DIV(DIV), .ACCESS_TICKS(TICKS)) i_dut (
    .CLK(clk), .RESET(reset), .MANUAL_RESET(man_rst), .STANDBY(stby),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ACC_REQ(acc_req), .ACC(acc), .ACC_ACK(ack),
    .CS_N(cs_n), .RD_N(rd_n), .WE_N(we_n));

  sbic_mem_model i_mem (
    .CLK(clk), .RESET(reset), .CS_N(cs_n), .RD_N(rd_n), .WE_N(we_n),
    .gap(gap), .len(len), .errs(merr), .cs(cs));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic hang();
    bad_count++;
    $display("MISMATCH t=%0t no answer", $time);
    give_verdict();
  endtask : hang

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_cyc(input int g, input int lo, input int hi);
    comparisons++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask : chk_cyc

  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // look between edges: pready launched at an edge has settled here
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    // completing edge: request still held up to it, released after
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one external access; request dropped at the edge after the acknowledging one
  task automatic access(input logic [2:0] s, input logic w);
    int k;
    k = 0;
    @(posedge clk);
    acc_req <= 1'b1;
    acc <= {s, w};
    // ack is a one-cycle pulse; look at it between edges
    do begin
      @(negedge clk);
      k++;
    end while (ack !== 1'b1 && k < 200);
    if (ack !== 1'b1) hang();
    @(posedge clk);
    acc_req <= 1'b0;
  endtask : access

  // two accesses; tolerance of one clock for bus clock phase
  task automatic pair(input logic [2:0] s1, input logic w1,
                      input logic [2:0] s2, input logic w2, input int t);
    access(s1, w1);
    access(s2, w2);
    chk_cyc(gap, base + t * DIV - 1, base + t * DIV + 1);
  endtask : pair

  initial begin
    {reset, man_rst, stby, psel, penable, pwrite, acc_req} = 7'b100_0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    acc = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_word({22'h0, cs_n, rd_n, we_n}, 32'h0000_03FF);
    // status after reset: sequencer idle, no previous access
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk_word(rd, 32'h0000_0001);
    // reset words, then all spaces set up before use
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      chk_word(rd, sbic_pkg::SBC_RESET);
      apb(1'b1, 8'(i * 4), (i == 1) ? 32'h7FC0_0600 : 32'h0000_0600);
    end
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk_word(rd, 32'h7FFF_FFFF);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk_word({rd[30:0], err}, 32'h0000_0001);
    // baseline with no idle cycles
    access(3'd0, 1'b1);
    access(3'd0, 1'b0);
    base = gap;
    chk_cyc(len, DIV * TICKS, DIV * TICKS);
    chk_word({24'h0, cs}, 32'h0000_00FE);
    // every code after a write; next space holds all sevens
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h00, {1'b0, 3'(c), 28'h000_0600});
      pair(3'd0, 1'b1, 3'd1, 1'b0, tbl[c]);
    end
    apb(1'b1, 8'h00, 32'h2000_0600);
    pair(3'd0, 1'b1, 3'd0, 1'b1, 2);
    apb(1'b1, 8'h00, 32'h0740_0600);
    pair(3'd0, 1'b0, 3'd2, 1'b1, 4);
    pair(3'd0, 1'b0, 3'd0, 1'b1, 8);
    apb(1'b1, 8'h00, 32'h7FC0_0600);
    pair(3'd0, 1'b0, 3'd0, 1'b0, 0);
    // standby holds a request; manual reset keeps words
    @(posedge clk);
    stby <= 1'b1;
    man_rst <= 1'b1;
    acc_req <= 1'b1;
    acc <= {3'd2, 1'b0};
    repeat (3) @(posedge clk);
    man_rst <= 1'b0;
    n = 0;
    // ack is looked at between edges, where it has settled
    repeat (30) begin
      @(negedge clk);
      if (ack === 1'b1) n++;
    end
    chk_cyc(n, 0, 0);
    @(posedge clk);
    stby <= 1'b0;
    access(3'd2, 1'b0);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk_word(rd, 32'h7FC0_0600);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk_word(rd, 32'h7FC0_0600);
    // status: last access was a read of space word 2, sequencer idle
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk_word(rd, 32'h0000_1201);
    chk_cyc(merr, 0, 0);
    give_verdict();
  end
endmodule : tb_sbic_space_bus_ctrl
